// [pkg/vmcr_pkg.sv]
package vmcr_pkg;
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int PMASK_HI  = 31;
    localparam int PMASK_LO  = 24;
    localparam int BP0_HI    = 23;
    localparam int BP0_LO    = 21;
    localparam int BP1_HI    = 20;
    localparam int BP1_LO    = 18;
    localparam int EOIM_BIT  = 9;
    localparam int CBPR_BIT  = 4;
    localparam int FIQ_BIT   = 3;
    localparam int ACK_BIT   = 2;
    localparam int ENG1_BIT  = 1;
    localparam int ENG0_BIT  = 0;
    localparam logic [31:0] WRITABLE_MASK = 32'hfffc021f;

    // ------------------------------------------------------------
    // access encoding
    // ------------------------------------------------------------
    localparam logic [3:0] CP_NUM   = 4'hf;
    localparam logic [2:0] CP_OPC1  = 3'h4;
    localparam logic [3:0] CP_CRN   = 4'hc;
    localparam logic [3:0] CP_CRM   = 4'hb;
    localparam logic [2:0] CP_OPC2  = 3'h7;
    localparam logic [5:0] TRAP_EC  = 6'h03;
    localparam logic [9:0] SPURIOUS_ID = 10'h3fe;
    localparam logic [2:0] BP_SAT   = 3'h7;

    typedef enum logic [1:0] {
        EL_USER  = 2'b00,
        EL_KERN  = 2'b01,
        EL_HYP   = 2'b10,
        EL_MON   = 2'b11
    } exc_level_t;

    typedef enum logic [1:0] {
        RSP_OK    = 2'b00,
        RSP_UNDEF = 2'b01,
        RSP_TRAP  = 2'b10
    } resp_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        exc_level_t level;
        logic [3:0] coproc;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } cp_req_t;

    typedef struct packed {
        logic [7:0] pmask;
        logic [2:0] bp0;
        logic [2:0] bp1;
        logic       eoim;
        logic       cbpr;
        logic       fiq;
        logic       ack;
        logic       eng1;
        logic       eng0;
    } vmcr_t;
endpackage : vmcr_pkg

// [src/vmcr_ctrl.sv]
// Behaviour
// - signal pending virtual interrupt only if priority higher than mask [31:24].
// - group 0 binary point splits priority; also governs group 1 when common set.
// - group 1 binary point governs group 1 preemption when common bit clear.
// - split mode clear: end-of-interrupt drops priority and deactivates.
// - split mode set: end-of-interrupt drops only; deactivate register deactivates.
// - common bit clear: each binary point governs its own group.
// - common bit set: guest reads g1 point as g0+1 saturated, writes ignored.
// - fast route bit sends group 0 as FIQ when 1, IRQ when 0.
// - fast route bit fixed at one when sysreg enable is always one.
// - legacy ack clear: group 1 highest pending reads as identifier 1022.
// - legacy ack set: group 1 highest pending reads its real identifier.
// - legacy ack bit fixed at zero when sysreg enable is always one.
// - bit 1 enables virtual group 1 interrupts.
// - bit 0 enables virtual group 0 interrupts.
// - warm reset leaves fields unknown; nothing relies on a reset value.
// - fields are shared storage with the guest-visible controls.
// - user level undefined; kernel traps code 0x03 when hypervisor enabled and trap bit set, else undefined.
// - hypervisor or monitor access completes only with its sysreg enable set.
// - without hypervisor level, monitor reads zero and writes are ignored.
// - register is 32 bits, accessed as a whole word via coprocessor interface.
// - hypervisor sysreg use requires guest kernel access to be supported.
module vmcr_ctrl #(
    parameter bit SRE_ALWAYS_ONE = 1'b0,   // non-secure sysreg enable hardwired
    parameter bit HYP_PRESENT    = 1'b1    // hypervisor level implemented
) (
    input  wire logic              MCLK,          // 100 MHz clock
    input  wire logic              ARST_N,        // async reset, active low
    input  wire vmcr_pkg::cp_req_t CP_REQ,        // coprocessor access request
    input  wire logic              HYP_SRE,       // hypervisor sysreg enable
    input  wire logic              MON_SRE,       // monitor sysreg enable
    input  wire logic              HYP_ENABLED,   // hypervisor level enabled
    input  wire logic              TRAP_GRP12,    // hypervisor trap control bit
    input  wire logic              G_WR,          // guest control write strobe
    input  wire vmcr_pkg::vmcr_t   G_WDATA,       // guest control write data
    input  wire logic              G_BP1_WR,      // guest write of g1 binary point
    input  wire logic [2:0]        G_BP1_WDATA,   // guest g1 binary point data
    input  wire logic              EOI_WR,        // guest end-of-interrupt write
    input  wire logic              DIR_WR,        // guest deactivate write
    input  wire logic              PEND_VALID,    // a pending interrupt exists
    input  wire logic [7:0]        PEND_PRIO,     // its priority
    input  wire logic              PEND_GRP1,     // it is group 1
    input  wire logic [9:0]        PEND_ID,       // its identifier
    output logic                   CP_ACK,        // access answered
    output vmcr_pkg::resp_t        CP_RESP,       // ok, undefined or trap
    output logic [5:0]             CP_EC,         // trap code
    output logic [31:0]            CP_RDATA,      // read data
    output vmcr_pkg::vmcr_t        G_VIEW,        // guest view of controls
    output logic [2:0]             G_BP1_RDATA,   // guest read of g1 binary point
    output logic [2:0]             PREEMPT_BP0,   // point used for group 0
    output logic [2:0]             PREEMPT_BP1,   // point used for group 1
    output logic                   VIRQ,          // virtual IRQ to core
    output logic                   VFIQ,          // virtual FIQ to core
    output logic                   PRIO_DROP,     // running priority drop pulse
    output logic                   DEACT,         // deactivate pulse
    output logic [9:0]             ACK_ID         // acknowledge/highest pending id
);
    import vmcr_pkg::*;

    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] pack_vmcr(input vmcr_t v);
        logic [31:0] w;
        w = 32'h0;
        w[PMASK_HI:PMASK_LO] = v.pmask;
        w[BP0_HI:BP0_LO]     = v.bp0;
        w[BP1_HI:BP1_LO]     = v.bp1;
        w[EOIM_BIT]          = v.eoim;
        w[CBPR_BIT]          = v.cbpr;
        w[FIQ_BIT]           = v.fiq;
        w[ACK_BIT]           = v.ack;
        w[ENG1_BIT]          = v.eng1;
        w[ENG0_BIT]          = v.eng0;
        return w;
    endfunction : pack_vmcr

    function automatic vmcr_t fix_bits(input vmcr_t v);
        vmcr_t f;
        f = v;
        if (SRE_ALWAYS_ONE) begin
            f.fiq = 1'b1;
            f.ack = 1'b0;
        end
        return f;
    endfunction : fix_bits

    function automatic logic [2:0] bp_plus_one(input logic [2:0] b);
        return (b == BP_SAT) ? BP_SAT : 3'(b + 3'h1);
    endfunction : bp_plus_one

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    logic  hit;
    resp_t resp_c;
    logic  hyp_ok;
    always_comb begin
        hit = CP_REQ.valid && CP_REQ.coproc == CP_NUM && CP_REQ.opc1 == CP_OPC1
              && CP_REQ.crn == CP_CRN && CP_REQ.crm == CP_CRM
              && CP_REQ.opc2 == CP_OPC2;
        hyp_ok = 1'b0;
        resp_c = RSP_UNDEF;
        case (CP_REQ.level)
            EL_USER: resp_c = RSP_UNDEF;
            EL_KERN: resp_c = (HYP_ENABLED && TRAP_GRP12) ? RSP_TRAP : RSP_UNDEF;
            EL_HYP: begin
                resp_c = HYP_SRE ? RSP_OK : RSP_UNDEF;
                hyp_ok = HYP_SRE;
            end
            EL_MON: begin
                resp_c = MON_SRE ? RSP_OK : RSP_UNDEF;
                hyp_ok = MON_SRE && HYP_PRESENT;
            end
            default: resp_c = RSP_UNDEF;
        endcase
    end

    // ------------------------------------------------------------
    // shared control storage
    // ------------------------------------------------------------
    // no reset on the fields: their warm reset value is unknown by design
    vmcr_t vm_r;
    vmcr_t vm_nxt;
    always_comb begin
        vm_nxt = vm_r;
        if (hit && CP_REQ.write && resp_c == RSP_OK && hyp_ok) begin
            vm_nxt.pmask = CP_REQ.wdata[PMASK_HI:PMASK_LO];
            vm_nxt.bp0   = CP_REQ.wdata[BP0_HI:BP0_LO];
            vm_nxt.bp1   = CP_REQ.wdata[BP1_HI:BP1_LO];
            vm_nxt.eoim  = CP_REQ.wdata[EOIM_BIT];
            vm_nxt.cbpr  = CP_REQ.wdata[CBPR_BIT];
            vm_nxt.fiq   = CP_REQ.wdata[FIQ_BIT];
            vm_nxt.ack   = CP_REQ.wdata[ACK_BIT];
            vm_nxt.eng1  = CP_REQ.wdata[ENG1_BIT];
            vm_nxt.eng0  = CP_REQ.wdata[ENG0_BIT];
        end else begin
            // guest writes land only in cycles with no completed hypervisor or monitor write
            if (G_WR) begin
                vm_nxt.pmask = G_WDATA.pmask;
                vm_nxt.bp0   = G_WDATA.bp0;
                vm_nxt.eoim  = G_WDATA.eoim;
                vm_nxt.cbpr  = G_WDATA.cbpr;
                vm_nxt.fiq   = G_WDATA.fiq;
                vm_nxt.ack   = G_WDATA.ack;
                vm_nxt.eng1  = G_WDATA.eng1;
                vm_nxt.eng0  = G_WDATA.eng0;
            end
            if (G_BP1_WR && !vm_r.cbpr) begin
                vm_nxt.bp1 = G_BP1_WDATA;
            end
        end
        vm_nxt = fix_bits(vm_nxt);
    end

    always_ff @(posedge MCLK) begin
        vm_r <= vm_nxt;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic        ack_nxt;
    resp_t       resp_nxt;
    logic [5:0]  ec_nxt;
    logic [31:0] rdata_nxt;
    logic [2:0]  pbp0_nxt;
    logic [2:0]  pbp1_nxt;
    logic [2:0]  gbp1_nxt;
    logic        above_mask;
    logic        virq_nxt;
    logic        vfiq_nxt;
    logic        drop_nxt;
    logic        deact_nxt;
    logic [9:0]  id_nxt;
    always_comb begin
        ack_nxt   = hit;
        resp_nxt  = hit ? resp_c : RSP_OK;
        ec_nxt    = (hit && resp_c == RSP_TRAP) ? TRAP_EC : 6'h0;
        rdata_nxt = 32'h0;
        if (hit && !CP_REQ.write && resp_c == RSP_OK && hyp_ok) begin
            rdata_nxt = pack_vmcr(vm_r) & WRITABLE_MASK;
        end
        pbp0_nxt = vm_r.bp0;
        pbp1_nxt = vm_r.cbpr ? vm_r.bp0 : vm_r.bp1;
        gbp1_nxt = vm_r.cbpr ? bp_plus_one(vm_r.bp0) : vm_r.bp1;
        // lower value means higher priority
        above_mask = PEND_VALID && (PEND_PRIO < vm_r.pmask);
        virq_nxt = 1'b0;
        vfiq_nxt = 1'b0;
        if (above_mask && PEND_GRP1 && vm_r.eng1) begin
            virq_nxt = 1'b1;
        end
        if (above_mask && !PEND_GRP1 && vm_r.eng0) begin
            if (vm_r.fiq) begin
                vfiq_nxt = 1'b1;
            end else begin
                virq_nxt = 1'b1;
            end
        end
        drop_nxt  = EOI_WR;
        // with split mode clear the deactivate register is unpredictable; ignored
        deact_nxt = vm_r.eoim ? DIR_WR : EOI_WR;
        id_nxt    = (PEND_GRP1 && !vm_r.ack) ? SPURIOUS_ID : PEND_ID;
    end

    always_ff @(posedge MCLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            CP_ACK      <= 1'b0;
            CP_RESP     <= RSP_OK;
            CP_EC       <= 6'h0;
            CP_RDATA    <= 32'h0;
            G_VIEW      <= '0;
            G_BP1_RDATA <= 3'h0;
            PREEMPT_BP0 <= 3'h0;
            PREEMPT_BP1 <= 3'h0;
            VIRQ        <= 1'b0;
            VFIQ        <= 1'b0;
            PRIO_DROP   <= 1'b0;
            DEACT       <= 1'b0;
            ACK_ID      <= 10'h0;
        end else begin
            CP_ACK      <= ack_nxt;
            CP_RESP     <= resp_nxt;
            CP_EC       <= ec_nxt;
            CP_RDATA    <= rdata_nxt;
            G_VIEW      <= vm_r;
            G_BP1_RDATA <= gbp1_nxt;
            PREEMPT_BP0 <= pbp0_nxt;
            PREEMPT_BP1 <= pbp1_nxt;
            VIRQ        <= virq_nxt;
            VFIQ        <= vfiq_nxt;
            PRIO_DROP   <= drop_nxt;
            DEACT       <= deact_nxt;
            ACK_ID      <= id_nxt;
        end
    end
endmodule : vmcr_ctrl

// [dv/vmcr_chk.sv]
// ------------------------------------------------------------
// access answers and storage follow-through
// ------------------------------------------------------------
module vmcr_chk
    import vmcr_pkg::*;
#(
    parameter bit SRE_ALWAYS_ONE = 1'b0   // mirrors the bound instance
) (
    input wire logic        MCLK,        // clock
    input wire logic        ARST_N,      // reset, active low
    input wire cp_req_t     CP_REQ,      // access request
    input wire logic        HYP_SRE,     // hyp sysreg enable
    input wire logic        HYP_ENABLED, // hyp level on
    input wire logic        TRAP_GRP12,  // trap bit
    input wire logic        G_WR,        // guest write
    input wire logic        G_BP1_WR,    // guest point write
    input wire logic        CP_ACK,      // answer
    input wire resp_t       CP_RESP,     // answer code
    input wire logic [5:0]  CP_EC,       // trap code
    input wire logic [31:0] CP_RDATA,    // read data
    input wire vmcr_t       G_VIEW       // guest view
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    logic hit, kern, hyp, calm;
    function automatic logic [31:0] fix_word(input logic [31:0] w);
        logic [31:0] f;
        f = w & WRITABLE_MASK;
        if (SRE_ALWAYS_ONE) begin
            f[FIQ_BIT] = 1'b1;
            f[ACK_BIT] = 1'b0;
        end
        return f;
    endfunction : fix_word
    function automatic vmcr_t fld(input logic [31:0] w);
        logic [31:0] f;
        f = fix_word(w);
        return {f[31:18], f[9], f[4:0]};
    endfunction : fld
    assign hit = CP_REQ.valid && CP_REQ.coproc == CP_NUM && CP_REQ.opc1 == CP_OPC1
        && CP_REQ.crn == CP_CRN && CP_REQ.crm == CP_CRM && CP_REQ.opc2 == CP_OPC2;
    assign kern = hit && CP_REQ.level == EL_KERN;
    // guest strobes excluded so the hypervisor value is the only writer in play
    assign hyp = hit && CP_REQ.level == EL_HYP && HYP_SRE && !G_WR && !G_BP1_WR;
    assign calm = !G_WR && !G_BP1_WR && !(hit && CP_REQ.write);
    sequence hyp_wr_s;
        hyp && CP_REQ.write ##1 calm;
    endsequence
    a_ack_on_hit: assert property (hit |=> CP_ACK) else $error("access not answered");
    a_no_stray: assert property (!hit |=> !CP_ACK) else $error("stray answer");
    a_user_undef: assert property (hit && CP_REQ.level == EL_USER |=> CP_RESP == RSP_UNDEF)
        else $error("user access not undefined");
    a_kern_trap: assert property (kern && HYP_ENABLED && TRAP_GRP12 |=>
        CP_RESP == RSP_TRAP && CP_EC == TRAP_EC) else $error("kernel access not trapped");
    a_kern_undef: assert property (kern && !(HYP_ENABLED && TRAP_GRP12) |=>
        CP_RESP == RSP_UNDEF) else $error("kernel access not undefined");
    a_hyp_gate: assert property (hit && CP_REQ.level == EL_HYP |=>
        CP_RESP == ($past(HYP_SRE) ? RSP_OK : RSP_UNDEF)) else $error("hyp gate wrong");
    a_rsvd_zero: assert property (CP_ACK |-> (CP_RDATA & ~WRITABLE_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    a_view_follow: assert property (hyp_wr_s |=> G_VIEW == fld($past(CP_REQ.wdata, 2)))
        else $error("guest view missed write");
    a_read_back: assert property (hyp_wr_s ##1 hyp && !CP_REQ.write |=>
        CP_RDATA == fix_word($past(CP_REQ.wdata, 3))) else $error("readback wrong");
endmodule : vmcr_chk

bind vmcr_ctrl vmcr_chk #(.SRE_ALWAYS_ONE(SRE_ALWAYS_ONE)) chk_u (.MCLK, .ARST_N, .CP_REQ,
    .HYP_SRE, .HYP_ENABLED, .TRAP_GRP12, .G_WR, .G_BP1_WR, .CP_ACK, .CP_RESP, .CP_EC,
    .CP_RDATA, .G_VIEW);

// [dv/core_model.sv]
// ------------------------------------------------------------
// core side: takes a request where its level first rises
// ------------------------------------------------------------
module core_model (
    input  wire logic mclk,      // core clock
    input  wire logic virq,      // virtual irq level
    input  wire logic vfiq,      // virtual fiq level
    output int        irq_rises, // irq requests taken
    output int        fiq_rises  // fiq requests taken
);
    timeunit 1ns;
    timeprecision 1ns;
    logic irq_r = 1'b0;
    logic fiq_r = 1'b0;
    initial begin
        irq_rises = 0;
        fiq_rises = 0;
    end
    always @(posedge mclk) begin
        if (virq && !irq_r) irq_rises <= irq_rises + 1;
        if (vfiq && !fiq_r) fiq_rises <= fiq_rises + 1;
        irq_r <= virq;
        fiq_r <= vfiq;
    end
endmodule : core_model

// [dv/vmcr_ctrl_tb.sv]
// ------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------
module vmcr_ctrl_tb;
    import vmcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 1'b0;
    logic ARST_N = 1'b0;
    logic HYP_SRE, MON_SRE, HYP_ENABLED, TRAP_GRP12, G_WR, G_BP1_WR, EOI_WR, DIR_WR;
    logic PEND_VALID, PEND_GRP1, CP_ACK, VIRQ, VFIQ, PRIO_DROP, DEACT;
    logic [2:0] G_BP1_WDATA, G_BP1_RDATA, PREEMPT_BP0, PREEMPT_BP1;
    logic [7:0] PEND_PRIO;
    logic [9:0] PEND_ID, ACK_ID;
    logic [5:0] CP_EC;
    logic [31:0] CP_RDATA, v, fx_rdata;
    cp_req_t CP_REQ;
    vmcr_t G_WDATA, G_VIEW;
    resp_t CP_RESP, fx_resp;
    int fail_count = 0, tests_run = 0, seed = 41997, cyc = 0, irq_n, fiq_n, nd, nx;
    bit fire;
    always #5 MCLK = ~MCLK;
    vmcr_ctrl dut_u (.MCLK, .ARST_N, .CP_REQ, .HYP_SRE, .MON_SRE, .HYP_ENABLED, .TRAP_GRP12,
        .G_WR, .G_WDATA, .G_BP1_WR, .G_BP1_WDATA, .EOI_WR, .DIR_WR, .PEND_VALID, .PEND_PRIO,
        .PEND_GRP1, .PEND_ID, .CP_ACK, .CP_RESP, .CP_EC, .CP_RDATA, .G_VIEW, .G_BP1_RDATA,
        .PREEMPT_BP0, .PREEMPT_BP1, .VIRQ, .VFIQ, .PRIO_DROP, .DEACT, .ACK_ID);
    // second build: sysreg enable hardwired, no hypervisor level
    vmcr_ctrl #(.SRE_ALWAYS_ONE(1'b1), .HYP_PRESENT(1'b0)) dut_fix_u (.MCLK, .ARST_N, .CP_REQ,
        .HYP_SRE, .MON_SRE, .HYP_ENABLED, .TRAP_GRP12, .G_WR, .G_WDATA, .G_BP1_WR, .G_BP1_WDATA,
        .EOI_WR, .DIR_WR, .PEND_VALID, .PEND_PRIO, .PEND_GRP1, .PEND_ID, .CP_ACK(),
        .CP_RESP(fx_resp), .CP_EC(), .CP_RDATA(fx_rdata), .G_VIEW(), .G_BP1_RDATA(),
        .PREEMPT_BP0(), .PREEMPT_BP1(), .VIRQ(), .VFIQ(), .PRIO_DROP(), .DEACT(), .ACK_ID());
    core_model core_u (.mclk(MCLK), .virq(VIRQ), .vfiq(VFIQ), .irq_rises(irq_n),
        .fiq_rises(fiq_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // answer registers on the taking edge itself, so outputs are read 1 ns after it
    task automatic acc(input exc_level_t lv, input logic wr, input logic [31:0] wd,
                       input logic [2:0] o2);
        @(posedge MCLK);
        CP_REQ <= '{1'b1, wr, lv, CP_NUM, CP_OPC1, CP_CRN, CP_CRM, o2, wd};
        @(posedge MCLK);
        CP_REQ.valid <= 1'b0;
        #1;
    endtask : acc
    task automatic pulse(input logic eoi);
        @(posedge MCLK);
        EOI_WR <= eoi;
        DIR_WR <= !eoi;
        @(posedge MCLK);
        EOI_WR <= 1'b0;
        DIR_WR <= 1'b0;
        nd = 0;
        nx = 0;
        repeat (4) begin
            #1;
            nd += PRIO_DROP;
            nx += DEACT;
            @(posedge MCLK);
        end
    endtask : pulse
    function automatic logic [1:0] exp_resp(input logic [1:0] lv);
        if (lv == 2'h0) return RSP_UNDEF;
        if (lv == 2'h1) return (HYP_ENABLED && TRAP_GRP12) ? RSP_TRAP : RSP_UNDEF;
        return ((lv == 2'h2) ? HYP_SRE : MON_SRE) ? RSP_OK : RSP_UNDEF;
    endfunction : exp_resp
    function automatic logic [2:0] sat(input logic [2:0] b);
        return (b == 3'h7) ? 3'h7 : b + 3'h1;
    endfunction : sat
    // hardwired build: fast route reads one, legacy ack reads zero
    function automatic logic [31:0] fixed(input logic [31:0] w);
        return {w[31:18], 8'h00, w[9], 4'h0, w[4], 2'b10, w[1:0]};
    endfunction : fixed
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        CP_REQ = '0;
        G_WDATA = '0;
        {HYP_SRE, MON_SRE, HYP_ENABLED, TRAP_GRP12, G_WR, G_BP1_WR, EOI_WR, DIR_WR} = 8'h00;
        {PEND_VALID, PEND_GRP1, PEND_PRIO, PEND_ID, G_BP1_WDATA} = 23'h0;
        repeat (6) @(posedge MCLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge MCLK);
        for (int i = 0; i < 64; i++) begin
            @(posedge MCLK);
            {HYP_ENABLED, TRAP_GRP12, HYP_SRE, MON_SRE} <= 4'(i >> 2);
            acc(exc_level_t'(i[1:0]), 1'b0, 32'h0, CP_OPC2);
            chk(CP_ACK, 1'b1);
            chk(CP_RESP, exp_resp(i[1:0]));
            if (CP_RESP === RSP_TRAP) chk(CP_EC, TRAP_EC);
        end
        acc(EL_HYP, 1'b0, 32'h0, 3'h1);
        chk(CP_ACK, 1'b0);
        $display("test access levels done");
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 32'h00e00010 : (i == 1) ? 32'hffffffff : $random(seed);
            acc(EL_HYP, 1'b1, v, CP_OPC2);
            acc(EL_HYP, 1'b0, 32'h0, CP_OPC2);
            chk(CP_RDATA, v & WRITABLE_MASK);
            chk(G_VIEW, {v[31:18], v[9], v[4:0]});
            chk(PREEMPT_BP0, v[23:21]);
            chk(PREEMPT_BP1, v[4] ? v[23:21] : v[20:18]);
            chk(G_BP1_RDATA, v[4] ? sat(v[23:21]) : v[20:18]);
            chk(fx_rdata, fixed(v));
        end
        acc(EL_MON, 1'b1, 32'hffffffff, CP_OPC2);
        acc(EL_MON, 1'b0, 32'h0, CP_OPC2);
        chk(CP_RDATA, WRITABLE_MASK);
        chk(fx_resp, RSP_OK);
        chk(fx_rdata, 32'h0);
        acc(EL_HYP, 1'b0, 32'h0, CP_OPC2);
        chk(fx_rdata, fixed(v));
        for (int i = 0; i < 6; i++) begin
            acc(EL_HYP, 1'b1, 32'h0, CP_OPC2);
            @(posedge MCLK);
            G_WR <= 1'b1;
            G_WDATA <= 20'($random(seed));
            @(posedge MCLK);
            G_WR <= 1'b0;
            G_BP1_WR <= 1'b1;
            G_BP1_WDATA <= 3'h5;
            @(posedge MCLK);
            G_BP1_WR <= 1'b0;
            acc(EL_HYP, 1'b0, 32'h0, CP_OPC2);
            chk(CP_RDATA, {G_WDATA.pmask, G_WDATA.bp0, G_WDATA.cbpr ? 3'h0 : 3'h5, 8'h00,
                G_WDATA.eoim, 4'h0, G_WDATA[4:0]});
        end
        $display("test storage done");
        for (int i = 0; i < 40; i++) begin
            v = $random(seed);
            acc(EL_HYP, 1'b1, v, CP_OPC2);
            @(posedge MCLK);
            {PEND_VALID, PEND_GRP1, PEND_ID} <= 12'($random(seed));
            PEND_PRIO <= (i < 4) ? v[31:24] : 8'($random(seed));
            repeat (3) @(posedge MCLK);
            #1;
            fire = PEND_VALID && PEND_PRIO < v[31:24] && (PEND_GRP1 ? v[1] : v[0]);
            chk(VFIQ, fire && !PEND_GRP1 && v[3]);
            chk(VIRQ, fire && !(!PEND_GRP1 && v[3]));
            if (PEND_VALID && PEND_GRP1) chk(ACK_ID, v[2] ? PEND_ID : 10'h3fe);
        end
        chk(irq_n != 0, 1'b1);
        $display("test signalling done");
        for (int m = 0; m < 2; m++) begin
            acc(EL_HYP, 1'b1, 32'(m) << 9, CP_OPC2);
            pulse(1'b1);
            chk(nd, 1);
            chk(nx, 1 - m);
            pulse(1'b0);
            chk(nd, 0);
            chk(nx, m);
        end
        $display("test end of interrupt done");
        complete_run();
    end
endmodule : vmcr_ctrl_tb
